// ---- src/pcfu_regs.svh ----
// register offsets, vectors and layout constants of the program counter fetch unit
`ifndef PCFU_REGS_SVH
`define PCFU_REGS_SVH

`define PCFU_OFF_PC_LOW       12'h000
`define PCFU_OFF_HIGH_LATCH   12'h004
`define PCFU_OFF_UPPER_LATCH  12'h008
`define PCFU_OFF_CTRL         12'h00C
`define PCFU_OFF_STATUS       12'h010
`define PCFU_OFF_PC_FULL      12'h014
`define PCFU_OFF_CFG_ONE      12'h018
`define PCFU_OFF_CFG_TWO      12'h01C
`define PCFU_OFF_CFG_THREE    12'h020
`define PCFU_OFF_CFG_RSVD     12'h024
`define PCFU_OFF_STACK_TOP    12'h028
`define PCFU_OFF_STACK_PTR    12'h02C
`define PCFU_OFF_MEM_TOP      12'h030

`define PCFU_RESET_VEC        21'h00_0000
`define PCFU_HIGH_VEC         21'h00_0008
`define PCFU_LOW_VEC          21'h00_0018
`define PCFU_PC_STEP          21'h00_0002
`define PCFU_CFG_BYTES        21'h00_0008
`define PCFU_CFG_LAST         3'h7
`define PCFU_MEM_TOP_8K       21'h00_1FFF
`define PCFU_MEM_TOP_16K      21'h00_3FFF
`define PCFU_MEM_TOP_32K      21'h00_7FFF
`define PCFU_STACK_MAX        5'h1F

`define PCFU_CTRL_WAKE_BIT    0
`define PCFU_CTRL_GLOBAL_INT_ENABLE_HIGH_BIT    1
`define PCFU_CTRL_GLOBAL_INT_ENABLE_LOW_BIT    2
`define PCFU_CTRL_HIGH_BIT    3
`define PCFU_CTRL_STEP_BIT    4
`define PCFU_CTRL_SIZE_LSB    8

`endif

// ---- src/pcfu_pkg.sv ----
// types shared by the program counter fetch unit
package pcfu_pkg;

   typedef enum logic [1:0] {
      PCFU_SIZE_8K,
      PCFU_SIZE_16K,
      PCFU_SIZE_32K,
      PCFU_SIZE_RSVD
   } pcfu_size_t;

   // transfer request from the instruction decoder
   typedef struct packed {
      logic        step;
      logic        jump;
      logic [20:0] target;
      logic        push;
      logic        pop;
      logic [20:0] pop_value;
   } pcfu_core_req_t;

   // fetch port toward the program memory array
   typedef struct packed {
      logic [20:0] addr;
      logic        valid;
   } pcfu_fetch_t;

endpackage : pcfu_pkg

// ---- src/pcfu_top.sv ----
// program counter, latches, vectors, configuration load and APB register slave
// =====================================================================
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "pcfu_regs.svh"

module pcfu_top
   import pcfu_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire pcfu_core_req_t core_req,
   output pcfu_fetch_t         fetch,
   input  wire logic [7:0]     mem_rdata,
   output logic      [7:0]     instr_byte,
   output logic                cfg_done,
   output logic      [7:0]     config_word_one,
   output logic      [7:0]     config_word_one_hi,
   output logic      [15:0]    config_word_two,
   output logic      [15:0]    config_word_three,
   output logic      [15:0]    config_word_reserved
);

   // =====================================================================
   // helpers
   function automatic logic [20:0] pcfu_mem_top(input pcfu_size_t sz);
      case (sz)
         PCFU_SIZE_8K:  pcfu_mem_top = `PCFU_MEM_TOP_8K;
         PCFU_SIZE_16K: pcfu_mem_top = `PCFU_MEM_TOP_16K;
         default:       pcfu_mem_top = `PCFU_MEM_TOP_32K;
      endcase
   endfunction : pcfu_mem_top

   function automatic logic [20:0] pcfu_align(input logic [20:0] a);
      pcfu_align = {a[20:1], 1'b0};
   endfunction : pcfu_align

   // =====================================================================
   // state
   typedef enum logic [1:0] {ST_CFG_ADDR, ST_CFG_DATA, ST_RUN} pcfu_state_t;

   pcfu_state_t   state_r;
   pcfu_size_t    size_r;
   logic [20:0]   pc_r;
   logic [7:0]    pc_high_latch_r;
   logic [4:0]    pc_upper_latch_r;
   logic [2:0]    cfg_idx_r;
   logic [63:0]   cfg_r;
   logic [4:0]    return_stack_pointer_r;
   logic [20:0]   stack_top_r;
   logic          wake_r;
   logic          wake_d_r;
   logic          global_int_enable_high_r;
   logic          global_int_enable_low_r;
   logic          irq_high_r;

   // =====================================================================
   // decode
   wire           apb_setup    = psel & ~penable;
   wire           apb_acc      = psel & penable;
   wire           wr_en        = apb_acc & pwrite;
   wire           rd_en        = apb_acc & ~pwrite;
   wire           hit_pcl      = paddr == `PCFU_OFF_PC_LOW;
   wire           hit_hl       = paddr == `PCFU_OFF_HIGH_LATCH;
   wire           hit_ul       = paddr == `PCFU_OFF_UPPER_LATCH;
   wire           hit_ctrl     = paddr == `PCFU_OFF_CTRL;
   wire           mapped       = hit_pcl | hit_hl | hit_ul | hit_ctrl
                               | (paddr == `PCFU_OFF_STATUS) | (paddr == `PCFU_OFF_PC_FULL)
                               | (paddr == `PCFU_OFF_CFG_ONE) | (paddr == `PCFU_OFF_CFG_TWO)
                               | (paddr == `PCFU_OFF_CFG_THREE) | (paddr == `PCFU_OFF_CFG_RSVD)
                               | (paddr == `PCFU_OFF_STACK_TOP) | (paddr == `PCFU_OFF_STACK_PTR)
                               | (paddr == `PCFU_OFF_MEM_TOP);
   wire           running      = state_r == ST_RUN;
   wire [20:0]    mem_top      = pcfu_mem_top(size_r);
   wire [20:0]    cfg_base     = mem_top - `PCFU_CFG_BYTES + 21'h00_0001;
   wire [20:0]    cfg_addr     = cfg_base + {18'h0_0000, cfg_idx_r};
   wire           wake_rise    = wake_r & ~wake_d_r;
   // wake only vectors when the matching global enable is on
   wire           wake_vec     = running & wake_rise & (irq_high_r ? global_int_enable_high_r : global_int_enable_low_r);
   wire [20:0]    wake_target  = irq_high_r ? `PCFU_HIGH_VEC : `PCFU_LOW_VEC;
   wire           pcl_write    = wr_en & hit_pcl & running;
   wire           pcl_read     = rd_en & hit_pcl;
   wire [20:0]    pc_step      = pc_r + `PCFU_PC_STEP;
   wire [20:0]    pc_from_lat  = {pc_upper_latch_r, pc_high_latch_r, pwdata[7:1], 1'b0};
   logic [20:0]   pc_nxt;
   logic [31:0]   rdata_nxt;

   // priority: reset vector, interrupt wake, software low-byte write, decoder jump, pop, step
   always_comb begin
      pc_nxt = pc_r;
      if (!running) begin
         pc_nxt = `PCFU_RESET_VEC;
      end else if (wake_vec) begin
         pc_nxt = wake_target;
      end else if (pcl_write) begin
         pc_nxt = pc_from_lat;
      end else if (core_req.jump) begin
         pc_nxt = pcfu_align(core_req.target);
      end else if (core_req.pop) begin
         pc_nxt = pcfu_align(core_req.pop_value);
      end else if (core_req.step) begin
         pc_nxt = pc_step;
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         `PCFU_OFF_PC_LOW:      rdata_nxt = {24'h00_0000, pc_r[7:0]};
         `PCFU_OFF_HIGH_LATCH:  rdata_nxt = {24'h00_0000, pc_high_latch_r};
         `PCFU_OFF_UPPER_LATCH: rdata_nxt = {27'h000_0000, pc_upper_latch_r};
         `PCFU_OFF_CTRL:        rdata_nxt = {22'h00_0000, size_r, 4'h0, irq_high_r, global_int_enable_low_r, global_int_enable_high_r, 1'b0};
         `PCFU_OFF_STATUS:      rdata_nxt = {31'h0000_0000, cfg_done};
         `PCFU_OFF_PC_FULL:     rdata_nxt = {11'h000, pc_r};
         `PCFU_OFF_CFG_ONE:     rdata_nxt = {16'h0000, config_word_one_hi, config_word_one};
         `PCFU_OFF_CFG_TWO:     rdata_nxt = {16'h0000, config_word_two};
         `PCFU_OFF_CFG_THREE:   rdata_nxt = {16'h0000, config_word_three};
         `PCFU_OFF_CFG_RSVD:    rdata_nxt = {16'h0000, config_word_reserved};
         `PCFU_OFF_STACK_TOP:   rdata_nxt = {11'h000, stack_top_r};
         `PCFU_OFF_STACK_PTR:   rdata_nxt = {27'h000_0000, return_stack_pointer_r};
         `PCFU_OFF_MEM_TOP:     rdata_nxt = {11'h000, mem_top};
         default:               rdata_nxt = 32'h0000_0000;
      endcase
   end

   // =====================================================================
   // configuration load sequencer, walks top eight bytes upward
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= ST_CFG_ADDR;
         cfg_idx_r <= 3'h0;
      end else begin
         case (state_r)
            ST_CFG_ADDR: state_r <= ST_CFG_DATA;
            ST_CFG_DATA: begin
               cfg_idx_r <= cfg_idx_r + 3'h1;
               state_r   <= (cfg_idx_r == `PCFU_CFG_LAST) ? ST_RUN : ST_CFG_ADDR;
            end
            ST_RUN:      state_r <= ST_RUN;
            default:     state_r <= ST_CFG_ADDR;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= 64'h0000_0000_0000_0000;
      end else if (state_r == ST_CFG_DATA) begin
         cfg_r[{cfg_idx_r, 3'h0} +: 8] <= mem_rdata;
      end
   end

   // =====================================================================
   // program counter and latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= `PCFU_RESET_VEC;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_high_latch_r  <= 8'h00;
         pc_upper_latch_r <= 5'h00;
      end else if (pcl_read) begin
         pc_high_latch_r  <= pc_r[15:8];
         pc_upper_latch_r <= pc_r[20:16];
      end else if (wr_en & hit_hl) begin
         pc_high_latch_r  <= pwdata[7:0];
      end else if (wr_en & hit_ul) begin
         pc_upper_latch_r <= pwdata[4:0];
      end
   end

   // =====================================================================
   // control bits and wake capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_int_enable_high_r     <= 1'b0;
         global_int_enable_low_r     <= 1'b0;
         irq_high_r <= 1'b0;
         size_r     <= PCFU_SIZE_32K;
         wake_r     <= 1'b0;
         wake_d_r   <= 1'b0;
      end else begin
         wake_d_r <= wake_r;
         if (wr_en & hit_ctrl) begin
            global_int_enable_high_r     <= pwdata[`PCFU_CTRL_GLOBAL_INT_ENABLE_HIGH_BIT];
            global_int_enable_low_r     <= pwdata[`PCFU_CTRL_GLOBAL_INT_ENABLE_LOW_BIT];
            irq_high_r <= pwdata[`PCFU_CTRL_HIGH_BIT];
            size_r     <= pcfu_size_t'(pwdata[`PCFU_CTRL_SIZE_LSB +: 2]);
            wake_r     <= pwdata[`PCFU_CTRL_WAKE_BIT];
         end else begin
            wake_r <= 1'b0;
         end
      end
   end

   // wake or decoder push: stack top takes the current counter, pointer advances up to 5'h1F; pop steps it back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         return_stack_pointer_r <= 5'h00;
         stack_top_r            <= `PCFU_RESET_VEC;
      end else if (wake_vec || (running && core_req.push && !core_req.pop)) begin
         stack_top_r <= pc_r;
         if (return_stack_pointer_r != `PCFU_STACK_MAX) begin
            return_stack_pointer_r <= return_stack_pointer_r + 5'h01;
         end
      end else if (running && core_req.pop && return_stack_pointer_r != 5'h00) begin
         return_stack_pointer_r <= return_stack_pointer_r - 5'h01;
         stack_top_r            <= core_req.pop_value;
      end
   end

   // =====================================================================
   // fetch port, dedicated to program memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch      <= '0;
         instr_byte <= 8'h00;
         cfg_done   <= 1'b0;
      end else begin
         fetch.addr  <= running ? pc_nxt : cfg_addr;
         fetch.valid <= running;
         // the array holds no data past its top, so read as zero there
         instr_byte  <= (fetch.addr > mem_top) ? 8'h00 : mem_rdata;
         cfg_done    <= running;
      end
   end

   assign config_word_one      = cfg_r[7:0];
   assign config_word_one_hi   = cfg_r[15:8];
   assign config_word_two      = cfg_r[31:16];
   assign config_word_three    = cfg_r[47:32];
   assign config_word_reserved = cfg_r[63:48];

   // =====================================================================
   // apb slave, no wait state: pready and read data come from flops set in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= 32'h0000_0000;
      end else begin
         pready          <= apb_setup;
         pslverr         <= apb_setup & ~mapped;
         prdata          <= (apb_setup & ~pwrite) ? rdata_nxt : 32'h0000_0000;
      end
   end

endmodule : pcfu_top

// ---- tb/pcfu_checker_assertions.sv ----
// concurrent checks on the ports of the program counter fetch unit
`timescale 1ns/10ps
// =====================================================================
// checker
module pcfu_checker
   import pcfu_pkg::*;
(
   input wire logic           pclk,
   input wire logic           presetn,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pready,
   input wire pcfu_core_req_t core_req,
   input wire pcfu_fetch_t    fetch,
   input wire logic [7:0]     mem_rdata,
   input wire logic [7:0]     instr_byte,
   input wire logic           cfg_done
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // the bus quiet this cycle and the last keeps pending wakes and low-byte writes out
   AST_PC_ALIGN: assert property (fetch.valid |-> fetch.addr[0] == 1'b0)
      else $error("fetch address is odd");
   AST_STEP_BY_TWO: assert property (fetch.valid && core_req.step && !core_req.jump && !core_req.pop
      && !psel && !$past(psel) |=> fetch.addr == $past(fetch.addr) + 21'h00_0002)
      else $error("sequential fetch did not advance by two");
   AST_JUMP_LOAD: assert property (fetch.valid && core_req.jump && !psel && !$past(psel)
      |=> fetch.addr == {$past(core_req.target[20:1]), 1'b0})
      else $error("direct load did not reach target");
   AST_ZERO_ABOVE_TOP: assert property (fetch.addr > 21'h00_7FFF |=> instr_byte == 8'h00)
      else $error("fetch above implemented memory not zero");
   AST_FETCH_PASS: assert property (fetch.addr <= 21'h00_1FFF |=> instr_byte == $past(mem_rdata))
      else $error("fetched byte not passed through");
   AST_RESET_VECTOR: assert property ($rose(fetch.valid) |-> fetch.addr == 21'h00_0000)
      else $error("run did not start at reset vector");
   AST_CFG_SPAN: assert property (!cfg_done && fetch.addr != 21'h00_0000
      |-> fetch.addr inside {[21'h00_7FF8:21'h00_7FFF]})
      else $error("configuration load outside top eight bytes");
   AST_CFG_STAYS: assert property ($rose(cfg_done) |=> cfg_done [*8])
      else $error("configuration done dropped");
   AST_APB_ANSWER: assert property (psel && !penable |=> pready)
      else $error("register access not answered");

   cover property ($rose(cfg_done));
   cover property (core_req.step && fetch.valid);
   cover property (core_req.jump && fetch.valid);
endmodule : pcfu_checker

bind pcfu_top pcfu_checker pcfu_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .core_req(core_req), .fetch(fetch), .mem_rdata(mem_rdata), .instr_byte(instr_byte),
   .cfg_done(cfg_done));

// ---- tb/pcfu_mem_model.sv ----
// program memory array stand-in feeding bytes to the fetch port
`timescale 1ns/10ps
// =====================================================================
// memory model
module pcfu_mem_model
   import pcfu_pkg::*;
(
   input  wire pcfu_fetch_t fetch,
   output logic [7:0]       mem_rdata
);
   // every address answers, so a zero above the top must come from the unit itself
   assign mem_rdata = fetch.addr[7:0] ^ fetch.addr[15:8] ^ 8'hA5;
endmodule : pcfu_mem_model

// ---- tb/tb.sv ----
// self-checking testbench of the program counter fetch unit
`timescale 1ns/10ps
`include "pcfu_regs.svh"
// =====================================================================
// bench
module tb;
   import pcfu_pkg::*;
   logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_done, er;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata, rd;
   pcfu_core_req_t core_req;
   pcfu_fetch_t    fetch;
   logic [7:0]     mem_rdata, instr_byte, config_word_one, config_word_one_hi;
   logic [15:0]    config_word_two, config_word_three, config_word_reserved;
   logic [20:0]    t;
   int             errors, check_count, i;
   logic [31:0]    wc [3] = '{32'h20B, 32'h205, 32'h203};
   logic [31:0]    wp [3] = '{32'h8, 32'h18, 32'h18};
   logic [31:0]    wt [3] = '{32'h100, 32'h8, 32'h8};
   logic [31:0]    ws [3] = '{32'h1, 32'h2, 32'h2};

   pcfu_top pcfu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_req(core_req), .fetch(fetch), .mem_rdata(mem_rdata), .instr_byte(instr_byte),
      .cfg_done(cfg_done), .config_word_one(config_word_one), .config_word_one_hi(config_word_one_hi),
      .config_word_two(config_word_two), .config_word_three(config_word_three),
      .config_word_reserved(config_word_reserved));
   pcfu_mem_model pcfu_mem_model_inst (.fetch(fetch), .mem_rdata(mem_rdata));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   function automatic logic [7:0] mf(input logic [20:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction : mf

   function automatic pcfu_core_req_t rq(input logic s, input logic j, input logic p, input logic [20:0] a);
      rq = '0;
      rq.step = s;
      rq.jump = j;
      rq.pop = p;
      rq.target = a;
      rq.pop_value = a;
   endfunction : rq

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   // one-cycle request, then the new address and one cycle later its byte
   task core(input pcfu_core_req_t r, input logic [20:0] ea, input logic [7:0] eb);
      @(posedge pclk);
      core_req <= r;
      @(posedge pclk);
      core_req <= '0;
      @(posedge pclk);
      chk(32'(fetch.addr), 32'(ea));
      @(posedge pclk);
      chk(32'(instr_byte), 32'(eb));
   endtask : core

   task tally_and_finish;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      #400_000;
      errors++;
      tally_and_finish();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      core_req = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      i = 0;
      while (cfg_done !== 1'b1 && i < 100) begin
         @(posedge pclk);
         i++;
      end
      chk(32'(config_word_one), 32'(mf(21'h00_7FF8)));
      chk(32'(config_word_one_hi), 32'(mf(21'h00_7FF9)));
      chk(32'(config_word_two), {16'h0, mf(21'h00_7FFB), mf(21'h00_7FFA)});
      chk(32'(config_word_three), {16'h0, mf(21'h00_7FFD), mf(21'h00_7FFC)});
      chk(32'(config_word_reserved), {16'h0, mf(21'h00_7FFF), mf(21'h00_7FFE)});
      chk(32'(fetch.addr), 32'h0);
      rdc(`PCFU_OFF_STATUS, 32'h1);
      rdc(`PCFU_OFF_HIGH_LATCH, 32'h0);
      core(rq(1'b1, 1'b0, 1'b0, 21'h0), 21'h2, mf(21'h2));
      core(rq(1'b1, 1'b0, 1'b0, 21'h0), 21'h4, mf(21'h4));
      apb(1'b1, `PCFU_OFF_HIGH_LATCH, 32'h12);
      apb(1'b1, `PCFU_OFF_UPPER_LATCH, 32'h1F);
      rdc(`PCFU_OFF_HIGH_LATCH, 32'h12);
      rdc(`PCFU_OFF_UPPER_LATCH, 32'h1F);
      apb(1'b1, `PCFU_OFF_PC_LOW, 32'h35);
      rdc(`PCFU_OFF_PC_FULL, 32'h1F_1234);
      chk(32'(instr_byte), 32'h0);
      core(rq(1'b0, 1'b1, 1'b0, 21'h1F_FFFE), 21'h1F_FFFE, 8'h00);
      core(rq(1'b1, 1'b0, 1'b0, 21'h0), 21'h0, mf(21'h0));
      rdc(`PCFU_OFF_HIGH_LATCH, 32'h12);
      core(rq(1'b0, 1'b0, 1'b1, 21'h100), 21'h100, mf(21'h100));
      rdc(`PCFU_OFF_UPPER_LATCH, 32'h1F);
      rdc(`PCFU_OFF_PC_LOW, 32'h0);
      rdc(`PCFU_OFF_HIGH_LATCH, 32'h1);
      rdc(`PCFU_OFF_UPPER_LATCH, 32'h0);
      // high wake, low wake, then high enable set but low priority chosen
      for (i = 0; i < 3; i++) begin
         apb(1'b1, `PCFU_OFF_CTRL, wc[i]);
         rdc(`PCFU_OFF_PC_FULL, wp[i]);
         rdc(`PCFU_OFF_STACK_TOP, wt[i]);
         rdc(`PCFU_OFF_STACK_PTR, ws[i]);
      end
      apb(1'b0, 12'h100, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      for (i = 0; i < 3; i++) begin
         t = (21'h00_2000 << i) - 21'h1;
         apb(1'b1, `PCFU_OFF_CTRL, 32'(i) << 8);
         core(rq(1'b0, 1'b1, 1'b0, t - 21'h1), t - 21'h1, mf(t - 21'h1));
         core(rq(1'b1, 1'b0, 1'b0, 21'h0), t + 21'h1, 8'h00);
      end
      rdc(`PCFU_OFF_CTRL, 32'h0000_0200);
      tally_and_finish();
   end
endmodule : tb
